// [scic_defs.svh]
// register offsets, field positions, reset values and timing counts of the card interface
`ifndef SCIC_DEFS_SVH
`define SCIC_DEFS_SVH

// register offsets
`define SCIC_ADDR_CTRL 4'h0
`define SCIC_ADDR_STATUS 4'h1
`define SCIC_ADDR_MASK 4'h2
`define SCIC_ADDR_WT2 4'h3
`define SCIC_ADDR_WT1 4'h4
`define SCIC_ADDR_WT0 4'h5
`define SCIC_ADDR_TXD 4'h6
`define SCIC_ADDR_RXD 4'h7
`define SCIC_ADDR_PIN 4'h8

// card_interface_control fields
`define SCIC_CTRL_SRST 7
`define SCIC_CTRL_POL 6
`define SCIC_CTRL_SEL_HI 5
`define SCIC_CTRL_SEL_LO 4
`define SCIC_CTRL_MODE 3
`define SCIC_CTRL_RUN 2
`define SCIC_CTRL_REP 1
`define SCIC_CTRL_BIT_ORDER_CONVENTION 0

// status and mask fields
`define SCIC_ST_PAR 0
`define SCIC_ST_RX 1
`define SCIC_ST_TX 2
`define SCIC_ST_WT 3
`define SCIC_ST_CARD 4
`define SCIC_ST_PRES 5

// pin control field
`define SCIC_PIN_IO 3

// reset values
`define SCIC_CTRL_RESET 8'h00
`define SCIC_WT_RESET 24'h002580
`define SCIC_PIN_RESET 1'b1

// timing and frame counts
`define SCIC_ETU_CLKS 372
`define SCIC_REPEAT_LIMIT 4
`define SCIC_BIT_PARITY 4'h9
`define SCIC_BIT_ERRSAMPLE 4'hA
`define SCIC_BIT_LAST 4'hB

`endif

// [scic_pkg.sv]
// types shared by the card interface modules
package scic_pkg;

  // character engine states, one-hot
  typedef enum logic [3:0]
  {
    SCIC_IDLE = 4'b0001,
    SCIC_TX = 4'b0010,
    SCIC_RX = 4'b0100,
    SCIC_GUARD = 4'b1000
  } scic_state_type;

endpackage

// [scic_sync.sv]
// three-stage synchroniser with agreement filter for pin inputs
module scic_sync #(
  parameter int WIDTH = 2
)
(
  input wire logic clock,
  input wire logic rst,
  input wire logic [WIDTH-1:0] pin,
  output logic [WIDTH-1:0] level
);

  logic [WIDTH-1:0] stage1;
  logic [WIDTH-1:0] stage2;
  logic [WIDTH-1:0] stage3;

  ////////////////////////////////////////////////////////////////////////////////
  // one chain per pin; a change counts once stages two and three agree
  for (genvar i = 0; i < WIDTH; i++)
  begin : g_chain
    always_ff @(posedge clock or posedge rst)
    begin
      if (rst)
      begin
        stage1[i] <= 1'b1;
        stage2[i] <= 1'b1;
        stage3[i] <= 1'b1;
        level[i] <= 1'b1;
      end
      else
      begin
        stage1[i] <= pin[i];
        stage2[i] <= stage1[i];
        stage3[i] <= stage2[i];
        if (stage2[i] == stage3[i])
        begin
          level[i] <= stage3[i];
        end
      end
    end
  end

endmodule

// [scic_wait_timer.sv]
// 24-bit waiting time counter with load, reload and underflow pulse
module scic_wait_timer (
  input wire logic clock,
  input wire logic rst,
  input wire logic clear,
  input wire logic run,
  input wire logic load,
  input wire logic reload,
  input wire logic tick,
  input wire logic [23:0] value,
  output logic underflow
);

  logic [23:0] count;

  ////////////////////////////////////////////////////////////////////////////////
  // counter: stopped unless run, loaded or reloaded from the wait value
  always_ff @(posedge clock or posedge rst)
  begin
    if (rst)
    begin
      count <= 24'h000000;
    end
    else if (clear)
    begin
      count <= 24'h000000;
    end
    else if (load || (run && reload))
    begin
      count <= value;
    end
    else if (run && tick && count != 24'h000000)
    begin
      count <= count - 24'h000001;
    end
  end

  // underflow pulse when the last unit expires
  always_ff @(posedge clock or posedge rst)
  begin
    if (rst)
    begin
      underflow <= 1'b0;
    end
    else
    begin
      underflow <= !clear && run && !reload && tick && count == 24'h000001;
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // checks
  a_timer_stopped: assert property (@(posedge clock) disable iff (rst)
    (!run && !load && !clear) |=> count == $past(count))
    else $error("wait counter moved while stopped");
  a_timer_load: assert property (@(posedge clock) disable iff (rst)
    (load && !clear) |=> count == $past(value))
    else $error("wait counter not loaded on top byte write");
  a_timer_reload: assert property (@(posedge clock) disable iff (rst)
    (run && reload && !clear) |=> count == $past(value))
    else $error("wait counter not reloaded on start bit");
  c_timer_underflow: cover property (@(posedge clock) disable iff (rst) underflow);

endmodule

// [scic_ctrl.sv]
// smart card interface control: registers, character engine, pin control, interrupt
`include "scic_defs.svh"

module scic_ctrl
  import scic_pkg::*;
#(
  parameter int ETU_CLKS = `SCIC_ETU_CLKS,
  parameter int REPEAT_LIMIT = `SCIC_REPEAT_LIMIT
)
(
  input wire logic clock,
  input wire logic rst,
  input wire logic [3:0] addr,
  input wire logic [7:0] wdata,
  input wire logic wr,
  input wire logic rd,
  output logic [7:0] rdata,
  input wire logic detect_pin,
  input wire logic io_in,
  output logic io_out,
  output logic io_oe,
  output logic [1:0] card_supply_select,
  output logic [2:0] card_supply_enable,
  output logic irq
);

  localparam int ETU_W = $clog2(ETU_CLKS);
  localparam logic [ETU_W-1:0] ETU_LAST = ETU_W'(ETU_CLKS - 1);
  localparam logic [ETU_W-1:0] ETU_MID = ETU_W'(ETU_CLKS / 2);
  localparam logic [2:0] LIMIT = 3'(REPEAT_LIMIT);

  ////////////////////////////////////////////////////////////////////////////////
  // helpers

  // bit reversal for msb-first convention
  function automatic logic [7:0] scic_reverse(input logic [7:0] v);
    logic [7:0] r;
    r = 8'h00;
    for (int i = 0; i < 8; i++)
    begin
      r[i] = v[7 - i];
    end
    return r;
  endfunction

  // supply select to one-hot {5 V, 3 V, 1.8 V}; 00 is off
  function automatic logic [2:0] scic_supply_decode(input logic [1:0] sel);
    logic [2:0] e;
    e = 3'h0;
    if (sel == 2'h1)
    begin
      e = 3'h1;
    end
    else if (sel == 2'h2)
    begin
      e = 3'h2;
    end
    else if (sel == 2'h3)
    begin
      e = 3'h4;
    end
    return e;
  endfunction

  ////////////////////////////////////////////////////////////////////////////////
  // declarations
  logic [7:0] card_interface_control;
  logic io_line_level;
  logic [23:0] wait_time_reload_value;
  logic [7:0] tx_data;
  logic [7:0] rx_data;
  logic [4:0] status;
  logic [4:0] mask;
  logic card_present;
  logic tx_pending;
  scic_state_type state;
  logic [ETU_W-1:0] etu_cnt;
  logic [3:0] bit_idx;
  logic [2:0] attempts;
  logic [8:0] shift;
  logic err_seen;
  logic drive_err;
  logic det_sync;
  logic io_line;
  logic wt_underflow;
  logic soft_rst;
  logic polarity;
  logic mode;
  logic run;
  logic rep;
  logic bit_order_convention;
  logic engine_on;
  logic etu_wrap;
  logic etu_mid;
  logic may_retry;
  logic char_start;
  logic [8:0] rx_logic;
  logic rx_err;
  logic rx_end;
  logic rx_retry;
  logic rx_done;
  logic tx_end;
  logic tx_ok;
  logic tx_fail;
  logic [7:0] tx_order;
  logic tx_bit_line;
  logic drive_low;
  logic presence_now;
  logic presence_chg;
  logic wr_ctrl;
  logic [4:0] set_bits;
  logic [4:0] clr_bits;
  logic [ETU_W-1:0] wt_div;
  logic wt_tick;
  logic [23:0] wt_value;

  ////////////////////////////////////////////////////////////////////////////////
  // field aliases and write decode
  assign soft_rst = card_interface_control[`SCIC_CTRL_SRST];
  assign polarity = card_interface_control[`SCIC_CTRL_POL];
  assign mode = card_interface_control[`SCIC_CTRL_MODE];
  assign run = card_interface_control[`SCIC_CTRL_RUN];
  assign rep = card_interface_control[`SCIC_CTRL_REP];
  assign bit_order_convention = card_interface_control[`SCIC_CTRL_BIT_ORDER_CONVENTION];
  assign wr_ctrl = wr && addr == `SCIC_ADDR_CTRL;
  assign engine_on = mode && !soft_rst;

  ////////////////////////////////////////////////////////////////////////////////
  // pin synchronisers
  scic_sync #(
    .WIDTH(2)
  ) u_sync (
    .clock(clock),
    .rst(rst),
    .pin({detect_pin, io_in}),
    .level({det_sync, io_line})
  );

  ////////////////////////////////////////////////////////////////////////////////
  // control register; soft reset bit survives its own reset
  always_ff @(posedge clock or posedge rst)
  begin
    if (rst)
    begin
      card_interface_control <= `SCIC_CTRL_RESET;
    end
    else
    begin
      if (wr_ctrl)
      begin
        card_interface_control[`SCIC_CTRL_SRST] <= wdata[`SCIC_CTRL_SRST];
      end
      if (soft_rst)
      begin
        card_interface_control[6:0] <= 7'h00;
      end
      else if (wr_ctrl)
      begin
        card_interface_control[6:0] <= wdata[6:0];
      end
    end
  end

  // data and setting registers
  always_ff @(posedge clock or posedge rst)
  begin
    if (rst)
    begin
      io_line_level <= `SCIC_PIN_RESET;
      wait_time_reload_value <= `SCIC_WT_RESET;
      tx_data <= 8'h00;
      mask <= 5'h00;
    end
    else if (soft_rst)
    begin
      io_line_level <= `SCIC_PIN_RESET;
      wait_time_reload_value <= `SCIC_WT_RESET;
      tx_data <= 8'h00;
      mask <= 5'h00;
    end
    else if (wr)
    begin
      if (addr == `SCIC_ADDR_PIN)
      begin
        io_line_level <= wdata[`SCIC_PIN_IO];
      end
      else if (addr == `SCIC_ADDR_WT2)
      begin
        wait_time_reload_value[23:16] <= wdata;
      end
      else if (addr == `SCIC_ADDR_WT1)
      begin
        wait_time_reload_value[15:8] <= wdata;
      end
      else if (addr == `SCIC_ADDR_WT0)
      begin
        wait_time_reload_value[7:0] <= wdata;
      end
      else if (addr == `SCIC_ADDR_TXD)
      begin
        tx_data <= wdata;
      end
      else if (addr == `SCIC_ADDR_MASK)
      begin
        mask <= wdata[4:0];
      end
    end
  end

  // transmit request; a new write wins over the start that clears it
  always_ff @(posedge clock or posedge rst)
  begin
    if (rst)
    begin
      tx_pending <= 1'b0;
    end
    else if (!engine_on)
    begin
      tx_pending <= 1'b0;
    end
    else if (wr && addr == `SCIC_ADDR_TXD)
    begin
      tx_pending <= 1'b1;
    end
    else if (state == SCIC_IDLE)
    begin
      tx_pending <= 1'b0;
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // character engine timing and decode
  assign etu_wrap = etu_cnt == ETU_LAST;
  assign etu_mid = etu_cnt == ETU_MID;
  assign may_retry = rep && attempts < LIMIT;
  assign char_start = engine_on && state == SCIC_IDLE && (tx_pending || !io_line);
  assign rx_logic = shift ^ {9{bit_order_convention}};
  assign rx_err = ^rx_logic;
  assign rx_end = engine_on && state == SCIC_RX && etu_wrap && bit_idx == `SCIC_BIT_PARITY;
  assign rx_retry = rx_end && rx_err && may_retry;
  assign rx_done = rx_end && !rx_retry;
  assign tx_end = engine_on && state == SCIC_TX && etu_wrap && bit_idx == `SCIC_BIT_LAST;
  assign tx_ok = tx_end && !err_seen;
  assign tx_fail = tx_end && err_seen && !may_retry;
  assign tx_order = bit_order_convention ? scic_reverse(tx_data) : tx_data;

  // line level of the current transmit bit
  always_comb
  begin
    tx_bit_line = 1'b1;
    if (bit_idx == 4'h0)
    begin
      tx_bit_line = 1'b0;
    end
    else if (bit_idx == `SCIC_BIT_PARITY)
    begin
      tx_bit_line = (^tx_data) ^ bit_order_convention;
    end
    else if (bit_idx < `SCIC_BIT_PARITY)
    begin
      tx_bit_line = tx_order[3'(bit_idx - 4'h1)] ^ bit_order_convention;
    end
  end

  assign drive_low = (state == SCIC_TX && !tx_bit_line) || (state == SCIC_GUARD && drive_err);

  // state machine of one character, with error signal and repetition
  always_ff @(posedge clock or posedge rst)
  begin
    if (rst)
    begin
      state <= SCIC_IDLE;
      etu_cnt <= '0;
      bit_idx <= 4'h0;
      attempts <= 3'h0;
      shift <= 9'h000;
      err_seen <= 1'b0;
      drive_err <= 1'b0;
    end
    else if (!engine_on)
    begin
      state <= SCIC_IDLE;
      etu_cnt <= '0;
      bit_idx <= 4'h0;
      attempts <= 3'h0;
      err_seen <= 1'b0;
      drive_err <= 1'b0;
    end
    else
    begin
      etu_cnt <= etu_wrap ? '0 : etu_cnt + 1'b1;
      case (state)
        SCIC_IDLE:
        begin
          bit_idx <= 4'h0;
          err_seen <= 1'b0;
          etu_cnt <= '0;
          if (tx_pending)
          begin
            state <= SCIC_TX;
          end
          else if (!io_line)
          begin
            state <= SCIC_RX;
          end
        end
        SCIC_TX:
        begin
          if (etu_mid && bit_idx == `SCIC_BIT_ERRSAMPLE && !io_line)
          begin
            err_seen <= 1'b1;
          end
          if (etu_wrap)
          begin
            if (bit_idx != `SCIC_BIT_LAST)
            begin
              bit_idx <= bit_idx + 4'h1;
            end
            else if (err_seen && may_retry)
            begin
              attempts <= attempts + 3'h1;
              bit_idx <= 4'h0;
              err_seen <= 1'b0;
            end
            else
            begin
              attempts <= 3'h0;
              state <= SCIC_IDLE;
            end
          end
        end
        SCIC_RX:
        begin
          if (etu_mid && bit_idx == 4'h0 && io_line)
          begin
            state <= SCIC_IDLE;
          end
          else if (etu_mid && bit_idx != 4'h0)
          begin
            shift <= {io_line, shift[8:1]};
          end
          if (etu_wrap)
          begin
            bit_idx <= bit_idx + 4'h1;
            if (bit_idx == `SCIC_BIT_PARITY)
            begin
              state <= SCIC_GUARD;
              drive_err <= rx_retry;
              attempts <= rx_retry ? attempts + 3'h1 : 3'h0;
            end
          end
        end
        SCIC_GUARD:
        begin
          if (etu_wrap)
          begin
            drive_err <= 1'b0;
            bit_idx <= bit_idx + 4'h1;
            if (bit_idx == `SCIC_BIT_LAST)
            begin
              state <= SCIC_IDLE;
            end
          end
        end
        default:
        begin
          state <= SCIC_IDLE;
        end
      endcase
    end
  end

  // received character, in the selected bit order
  always_ff @(posedge clock or posedge rst)
  begin
    if (rst)
    begin
      rx_data <= 8'h00;
    end
    else if (soft_rst)
    begin
      rx_data <= 8'h00;
    end
    else if (rx_done)
    begin
      rx_data <= bit_order_convention ? scic_reverse(rx_logic[7:0]) : rx_logic[7:0];
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // pin drive: manual level or open-drain engine output
  always_ff @(posedge clock or posedge rst)
  begin
    if (rst)
    begin
      io_out <= 1'b1;
      io_oe <= 1'b0;
    end
    else if (!mode || soft_rst)
    begin
      io_out <= io_line_level;
      io_oe <= !soft_rst;
    end
    else
    begin
      io_out <= 1'b0;
      io_oe <= drive_low;
    end
  end

  // supply select outputs
  always_ff @(posedge clock or posedge rst)
  begin
    if (rst)
    begin
      card_supply_select <= 2'h0;
      card_supply_enable <= 3'h0;
    end
    else
    begin
      card_supply_select <= card_interface_control[`SCIC_CTRL_SEL_HI:`SCIC_CTRL_SEL_LO];
      card_supply_enable <= scic_supply_decode(
        card_interface_control[`SCIC_CTRL_SEL_HI:`SCIC_CTRL_SEL_LO]);
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // waiting time unit divider, apart from the engine so idle time counts too
  always_ff @(posedge clock or posedge rst)
  begin
    if (rst)
    begin
      wt_div <= '0;
    end
    else if (soft_rst || !run || char_start)
    begin
      wt_div <= '0;
    end
    else
    begin
      wt_div <= wt_tick ? '0 : wt_div + 1'b1;
    end
  end

  assign wt_tick = wt_div == ETU_LAST;
  // a top byte write loads the new top byte with the stored lower bytes
  assign wt_value = (wr && addr == `SCIC_ADDR_WT2) ? {wdata, wait_time_reload_value[15:0]} :
                    wait_time_reload_value;

  // waiting time counter
  scic_wait_timer u_wait (
    .clock(clock),
    .rst(rst),
    .clear(soft_rst),
    .run(run),
    .load(wr && addr == `SCIC_ADDR_WT2 && !run),
    .reload(char_start),
    .tick(wt_tick),
    .value(wt_value),
    .underflow(wt_underflow)
  );

  ////////////////////////////////////////////////////////////////////////////////
  // card presence from switch level and polarity
  assign presence_now = det_sync ^ polarity;
  assign presence_chg = !soft_rst && presence_now != card_present;

  always_ff @(posedge clock or posedge rst)
  begin
    if (rst)
    begin
      card_present <= 1'b0;
    end
    else if (soft_rst)
    begin
      card_present <= 1'b0;
    end
    else
    begin
      card_present <= presence_now;
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // sticky status, write one to clear, set wins
  assign clr_bits = (wr && addr == `SCIC_ADDR_STATUS) ? wdata[4:0] : 5'h00;
  assign set_bits = {presence_chg, wt_underflow, tx_ok, rx_done,
                     tx_fail || (rx_done && rx_err)};

  always_ff @(posedge clock or posedge rst)
  begin
    if (rst)
    begin
      status <= 5'h00;
    end
    else if (soft_rst)
    begin
      status <= 5'h00;
    end
    else
    begin
      status <= (status & ~clr_bits) | set_bits;
    end
  end

  assign irq = |(status & mask);

  ////////////////////////////////////////////////////////////////////////////////
  // read port, data in the cycle after the strobe
  always_ff @(posedge clock or posedge rst)
  begin
    if (rst)
    begin
      rdata <= 8'h00;
    end
    else if (!rd)
    begin
      rdata <= 8'h00;
    end
    else if (addr == `SCIC_ADDR_CTRL)
    begin
      rdata <= card_interface_control;
    end
    else if (addr == `SCIC_ADDR_STATUS)
    begin
      rdata <= {2'h0, card_present, status};
    end
    else if (addr == `SCIC_ADDR_MASK)
    begin
      rdata <= {3'h0, mask};
    end
    else if (addr == `SCIC_ADDR_WT2)
    begin
      rdata <= wait_time_reload_value[23:16];
    end
    else if (addr == `SCIC_ADDR_WT1)
    begin
      rdata <= wait_time_reload_value[15:8];
    end
    else if (addr == `SCIC_ADDR_WT0)
    begin
      rdata <= wait_time_reload_value[7:0];
    end
    else if (addr == `SCIC_ADDR_TXD)
    begin
      rdata <= tx_data;
    end
    else if (addr == `SCIC_ADDR_RXD)
    begin
      rdata <= rx_data;
    end
    else if (addr == `SCIC_ADDR_PIN)
    begin
      rdata <= {4'h0, io_line_level, 3'h0};
    end
    else
    begin
      rdata <= 8'h00;
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // checks
  default clocking cb @(posedge clock); endclocking
  default disable iff (rst);

  a_manual_pin_level: assert property (!mode && !soft_rst |=> io_oe && io_out == $past(io_line_level))
    else $error("manual pin does not follow level bit");
  a_engine_open_drain: assert property (engine_on |=> !io_out)
    else $error("engine drove pin high");
  a_supply_onehot: assert property (##1 card_supply_enable ==
    scic_supply_decode($past(card_interface_control[`SCIC_CTRL_SEL_HI:`SCIC_CTRL_SEL_LO])))
    else $error("supply enable does not match select");
  a_presence_polarity: assert property (!soft_rst && !$past(soft_rst) ##1 !soft_rst |->
    card_present == ($past(det_sync) != $past(polarity)))
    else $error("presence disagrees with switch polarity");
  a_soft_reset_clear: assert property (soft_rst |=> state == SCIC_IDLE && status == 5'h00)
    else $error("soft reset did not clear interface");
  a_repeat_bound: assert property (attempts <= LIMIT)
    else $error("retry count beyond limit");
  a_tx_fail_flags: assert property (tx_fail |=> status[`SCIC_ST_PAR] && !$rose(status[`SCIC_ST_TX]))
    else $error("failed transmission flags wrong");
  a_rx_error_flags: assert property (rx_done && rx_err |=> status[`SCIC_ST_PAR] && status[`SCIC_ST_RX])
    else $error("received parity error flags wrong");
  a_rx_retry_signal: assert property (rx_retry |-> ##2 (io_oe && state == SCIC_GUARD) [*2])
    else $error("error signal not driven on retry");
  a_underflow_irq: assert property (wt_underflow && mask[`SCIC_ST_WT] && !soft_rst |=> irq)
    else $error("underflow did not raise interrupt");

  c_tx_complete: cover property (tx_ok);
  c_rx_complete: cover property (rx_done && !rx_err);
  c_tx_retry: cover property (tx_end && err_seen && may_retry);
  c_rx_retry: cover property (rx_retry);

endmodule

// [scic_card.sv]
// behavioural card on the open-drain character line
module scic_card #(
  parameter int E = 16
)
(
  input wire logic clock,
  input wire logic line,
  input wire logic listen,
  input wire logic refuse,
  output logic pull_low = 1'b0,
  output logic [8:0] raw,
  output int got = 0,
  output int errs = 0
);
  timeunit 1ns;
  timeprecision 1ps;
  ////////////////////////////////////////////////////////////////////////
  // take a character, refuse it with a low error unit when told to
  always @(posedge clock)
    if (listen && line === 1'b0)
    begin
      repeat (E / 2) @(posedge clock);
      for (int i = 0; i < 9; i++)
      begin
        repeat (E) @(posedge clock);
        raw[i] = line;
      end
      repeat (E / 2) @(posedge clock);
      pull_low <= refuse;
      repeat (E) @(posedge clock);
      pull_low <= 1'b0;
      got++;
    end

  // start unit, nine line levels, then look for the error unit
  task automatic send(input logic [8:0] bits);
    @(posedge clock);
    pull_low <= 1'b1;
    for (int i = 0; i < 9; i++)
    begin
      repeat (E) @(posedge clock);
      pull_low <= ~bits[i];
    end
    repeat (E) @(posedge clock);
    pull_low <= 1'b0;
    repeat (E / 2) @(posedge clock);
    if (line === 1'b0) errs++;
    repeat (2 * E) @(posedge clock);
  endtask
endmodule

// [smart_card_iface_control_tb_top.sv]
// self-checking bench for the card interface control block
module smart_card_iface_control_tb_top
  import scic_pkg::*;
();
  timeunit 1ns;
  timeprecision 1ps;
  localparam int E = 16;
  localparam int L = 4;
  logic clock = 1'b0;
  logic rst = 1'b1;
  logic wr = 1'b0;
  logic rd = 1'b0;
  logic detect_pin = 1'b0;
  logic listen = 1'b0;
  logic refuse = 1'b0;
  logic [3:0] addr = 4'h0;
  logic [7:0] wdata = 8'h00;
  logic rd_d, io_out, io_oe, irq, pull_low;
  logic [7:0] rdata, d;
  logic [1:0] card_supply_select;
  logic [2:0] card_supply_enable;
  logic [8:0] raw;
  logic [7:0] exp_q [$];
  int got, errs, n, g0;
  int error_cnt = 0;
  int cmp_count = 0;
  int seed = 32'h199B;
  // open-drain wire with pull-up
  wire io_line = pull_low ? 1'b0 : (io_oe ? io_out : 1'b1);

  scic_ctrl #(.ETU_CLKS(E), .REPEAT_LIMIT(L)) u_dut (.io_in(io_line), .*);
  scic_card #(.E(E)) u_card (.line(io_line), .*);

  ////////////////////////////////////////////////////////////////////////
  task automatic check(input string s, input logic [8:0] seen, input logic [8:0] want);
    cmp_count++;
    if (seen !== want)
    begin
      error_cnt++;
      $display("wrong value %s expected %h seen %h", s, want, seen);
    end
  endtask
  task automatic wr_reg(input logic [3:0] a, input logic [7:0] v);
    @(posedge clock);
    addr <= a;
    wdata <= v;
    wr <= 1'b1;
    @(posedge clock);
    wr <= 1'b0;
  endtask
  task automatic rd_reg(input logic [3:0] a, input logic [7:0] v);
    @(posedge clock);
    addr <= a;
    rd <= 1'b1;
    exp_q.push_back(v);
    @(posedge clock);
    rd <= 1'b0;
  endtask
  // line levels of data and parity in wire order
  function automatic logic [8:0] line_of(input logic [7:0] v, input logic c);
    logic [8:0] r;
    for (int i = 0; i < 8; i++) r[i] = c ? ~v[7 - i] : v[i];
    r[8] = c ? ~^v : ^v;
    return r;
  endfunction
  task automatic conclude();
    $display("mismatches %0d, comparisons %0d", error_cnt, cmp_count);
    if (error_cnt == 0 && cmp_count > 0)
      $display("TEST PASSED");
    else
      $display("TEST FAILED");
    $finish;
  endtask

  ////////////////////////////////////////////////////////////////////////
  // clock, read monitor and watchdog
  initial forever #4 clock = ~clock;
  always @(posedge clock) rd_d <= rd;
  always @(negedge clock)
    if (rd_d === 1'b1) check("rdata", 9'(rdata), 9'(exp_q.pop_front()));
  initial
  begin
    repeat (30000) @(posedge clock);
    error_cnt++;
    conclude();
  end

  // main sequence
  initial
  begin
    repeat (12) @(posedge clock);
    rst <= 1'b0;
    rd_reg(4'h0, 8'h00);
    rd_reg(4'h4, 8'h25);
    rd_reg(4'h8, 8'h08);
    rd_reg(4'hF, 8'h00);
    wr_reg(4'h0, 8'h80);
    wr_reg(4'h0, 8'hFF);
    rd_reg(4'h0, 8'h80);
    check("oe", 9'(io_oe), 9'h000);
    wr_reg(4'h0, 8'h00);
    for (int i = 0; i < 4; i++)
    begin
      wr_reg(4'h0, 8'(i * 16));
      d = {3'h0, i[1:0], i == 3, i == 2, i == 1};
      repeat (2) @(negedge clock);
      check("supply", 9'({card_supply_select, card_supply_enable}), 9'(d));
    end
    repeat (3)
    begin
      d = 8'($random(seed));
      wr_reg(4'h8, {4'h0, d[0], 3'h0});
      repeat (2) @(negedge clock);
      check("pin", 9'({io_oe, io_out}), {7'h00, 1'b1, d[0]});
    end
    // card detect with both switch types, masked interrupt
    wr_reg(4'h2, 8'h10);
    detect_pin <= 1'b1;
    repeat (8) @(posedge clock);
    check("irq", 9'(irq), 9'h001);
    rd_reg(4'h1, 8'h30);
    wr_reg(4'h0, 8'h40);
    repeat (4) @(posedge clock);
    wr_reg(4'h1, 8'h1F);
    rd_reg(4'h1, 8'h00);
    check("irq", 9'(irq), 9'h000);
    detect_pin <= 1'b0;
    wr_reg(4'h0, 8'h00);
    // stopped counter loaded by the top byte, then run to underflow
    wr_reg(4'h5, 8'h03);
    wr_reg(4'h4, 8'h00);
    wr_reg(4'h3, 8'h00);
    wr_reg(4'h1, 8'h1F);
    wr_reg(4'h2, 8'h08);
    wr_reg(4'h0, 8'h04);
    repeat (E) @(posedge clock);
    check("irq", 9'(irq), 9'h000);
    repeat (3 * E) @(posedge clock);
    check("irq", 9'(irq), 9'h001);
    rd_reg(4'h1, 8'h08);
    wr_reg(4'h0, 8'h00);
    wr_reg(4'h1, 8'h1F);
    wr_reg(4'h8, 8'h08);
    listen <= 1'b1;
    // transmit: accepted, refused, refused with retries
    for (int j = 0; j < 4; j++)
    begin
      refuse <= j[1];
      n = (j == 3) ? L + 1 : 1;
      g0 = got;
      d = 8'($random(seed));
      wr_reg(4'h0, {4'h0, 1'b1, 1'b0, j == 3, j[0]});
      wr_reg(4'h6, d);
      for (int k = 0; k < 4000 && got < g0 + n; k++) @(posedge clock);
      // a full frame more, so one retry too many would show
      repeat (13 * E) @(posedge clock);
      check("tries", 9'(got - g0), 9'(n));
      check("line", raw, line_of(d, j[0]));
      rd_reg(4'h1, j[1] ? 8'h01 : 8'h04);
      wr_reg(4'h1, 8'h1F);
    end
    listen <= 1'b0;
    // receive: both conventions, mismatch without and with retries
    for (int i = 0; i < 4; i++)
    begin
      d = 8'($random(seed));
      n = (i == 3) ? L + 1 : 1;
      g0 = errs;
      wr_reg(4'h0, {4'h0, 1'b1, 1'b0, i == 3, i[0]});
      repeat (n) u_card.send(line_of(d, i[0] ^ i[1]));
      check("errsig", 9'(errs - g0), (i == 3) ? 9'(L) : 9'h000);
      rd_reg(4'h1, i[1] ? 8'h03 : 8'h02);
      if (!i[1]) rd_reg(4'h7, d);
      wr_reg(4'h1, 8'h1F);
    end
    conclude();
  end
endmodule
